// *** design/hsp_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module hsp_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("hsp_fifo: DEPTH must be a power of two >= 2");
    end
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic push;
  logic pop;
  // ===========================================================================
  // Full and empty from pointer wrap bits
  assign out_valid_out = (wp_r != rp_r);
  assign in_ready_out = !((wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]));
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem_r[rp_r[AW-1:0]];
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= in_data_in;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule : hsp_fifo
`default_nettype wire

// *** design/hsp_port.sv ***
`timescale 1ns/1ps
`default_nettype none
// Function
// R01: Serial input sampled on clock rise, serial output changed on clock fall.
// R02: Master lowers chip select, then sends a 16-bit command word first.
// R03: Command bits 15..11 must be 11100 or the transfer is ignored.
// R04: Command bit 10 high means read, low means write.
// R05: Command bits 9..0 load the address pointer as first register.
// R06: Each 16-bit write word goes to pointed register, pointer then increments.
// R07: Write runs until chip select rises; pointer never wraps, later data dropped.
// R08: Single write needs 32 bits with chip select held low.
// R09: Serial clock may idle high or low between transfers.
// R10: Read words take 16 clocks; first bit on first fall after command.
// R11: Read increments per word; at maximum the last register repeats.
// R12: Serial output stays high impedance except while shifting read data.
// R13: Two-wire address is 01011 plus high strap then low strap.
// R14: Two-wire variant is slave only, never starts a transfer.
// R15: Matching address is acknowledged low on ninth clock; mismatch stays idle.
// R16: Stop condition returns to idle and clears the pointer.
// R17: Two address bytes follow write address; only ten low bits used.
// R18: Third byte is data high half, fourth byte data low half.
// R19: Pointer increments after each write word, no wrap, excess dropped.
// R20: Registers are 16 bits from two bytes; master sends even byte count.
// R21: Every received byte, including middle ones, is acknowledged low.
// R22: Master ends with stop or keeps bus with repeated start.
// R23: Two-wire read first sets pointer by write, then read address.
// R24: Read sends high byte then low, increments, repeats last at maximum.
// R25: Register written only after all 16 bits; aborted word changes nothing.
module hsp_port
  import hsp_pkg::*;
#(
  parameter bit I2C_VARIANT = 1'b0
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic spi_cs_n_in,
  input wire logic sclk_in,
  input wire logic serial_in_line_in,
  output logic serial_out_line_out,
  output logic serial_out_line_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic addr_strap_low_in,
  input wire logic addr_strap_high_in,
  output logic [hsp_pkg::ADDR_W-1:0] rd_addr_out,
  input wire logic [hsp_pkg::DATA_W-1:0] rd_data_in,
  output logic wr_valid_out,
  output hsp_pkg::hsp_wr_s wr_word_out,
  input wire logic wr_ready_in,
  output logic wr_space_out
);
  import hsp_pkg::*;

  // ===========================================================================
  // Pin synchronisers: stage 1 feeds only stage 2, stage 3 finds edges
  logic [5:0] s1_r;
  logic [5:0] s2_r;
  logic [2:0] s3_r;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s1_r <= 6'h3f;
      s2_r <= 6'h3f;
      s3_r <= 3'h7;
    end else begin
      s1_r <= {addr_strap_high_in, addr_strap_low_in, sda_in, serial_in_line_in, sclk_in,
               spi_cs_n_in};
      s2_r <= s1_r;
      s3_r <= {s2_r[3], s2_r[1], s2_r[0]};
    end
  end
  logic cs_n_s;
  logic clk_s;
  logic din_s;
  logic sda_s;
  logic clk_rise;
  logic clk_fall;
  logic i2c_start;
  logic i2c_stop;
  logic [6:0] own_addr;
  assign cs_n_s = s2_r[0];
  assign clk_s = s2_r[1];
  assign din_s = s2_r[2];
  assign sda_s = s2_r[3];
  assign clk_rise = clk_s && !s3_r[1];
  assign clk_fall = !clk_s && s3_r[1];
  assign i2c_start = I2C_VARIANT && clk_s && s3_r[1] && !sda_s && s3_r[2];
  assign i2c_stop = I2C_VARIANT && clk_s && s3_r[1] && sda_s && !s3_r[2];
  assign own_addr = {DEV_ADDR_HI, s2_r[5], s2_r[4]}; // [R13]

  // ===========================================================================
  // Pointer step that holds at the top address
  function automatic logic [ADDR_W-1:0] hsp_adv(input logic [ADDR_W-1:0] p);
    hsp_adv = (p == PTR_MAX) ? p : p + 10'h001;
  endfunction : hsp_adv

  // ===========================================================================
  // Link state machine, pointer and shifters
  hsp_state_e state_r;
  logic [3:0] cnt_r;
  logic [15:0] sh_r;
  logic [15:0] tx_r;
  logic [ADDR_W-1:0] ptr_r;
  logic end_r;
  logic ack_r;
  logic rd_dir_r;
  logic [1:0] byte_idx_r;
  logic hi_sel_r;
  logic [7:0] hi_byte_r;
  logic push_r;
  hsp_wr_s word_r;
  logic [15:0] cmd_w;
  logic [7:0] tx_byte;
  assign cmd_w = {sh_r[14:0], din_s};
  assign tx_byte = hi_sel_r ? rd_data_in[15:8] : rd_data_in[7:0];
  assign rd_addr_out = ptr_r;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 16'h0000;
      tx_r <= 16'h0000;
      ptr_r <= PTR_RST;
      end_r <= 1'b0;
      ack_r <= 1'b0;
      rd_dir_r <= 1'b0;
      byte_idx_r <= 2'h0;
      hi_sel_r <= 1'b1;
      hi_byte_r <= 8'h00;
      push_r <= 1'b0;
      word_r <= '0;
      serial_out_line_out <= 1'b0;
      serial_out_line_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      push_r <= 1'b0;
      if (!I2C_VARIANT) begin
        if (cs_n_s) begin
          // Chip select high aborts any partial word
          state_r <= ST_IDLE; // [R07] [R25]
          cnt_r <= 4'h0;
          serial_out_line_oe_out <= 1'b0; // [R12]
        end else begin
          if (state_r == ST_IDLE) begin
            state_r <= ST_CMD; // [R09]
            cnt_r <= 4'h0;
          end
          if (clk_rise && state_r != ST_IDLE) begin
            sh_r <= cmd_w; // [R01]
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == WORD_LAST) begin
              case (state_r)
                ST_CMD: begin
                  if (cmd_w[CMD_EN_HI:CMD_EN_LO] != CMD_ENABLE) begin
                    state_r <= ST_SKIP; // [R03]
                  end else begin
                    ptr_r <= cmd_w[ADDR_W-1:0]; // [R05]
                    end_r <= 1'b0;
                    state_r <= cmd_w[CMD_RW_BIT] ? ST_SRD : ST_SWR; // [R04]
                  end
                end
                ST_SWR: begin
                  push_r <= !end_r; // [R06] [R07] [R25]
                  word_r <= '{addr: ptr_r, data: cmd_w};
                  end_r <= end_r | (ptr_r == PTR_MAX);
                  ptr_r <= hsp_adv(ptr_r);
                end
                ST_SRD: begin
                  ptr_r <= hsp_adv(ptr_r); // [R11]
                end
                default: begin
                end
              endcase
            end
          end
          if (clk_fall && state_r == ST_SRD) begin
            serial_out_line_oe_out <= 1'b1; // [R10] [R12]
            if (cnt_r == 4'h0) begin
              serial_out_line_out <= rd_data_in[15]; // [R01] [R10]
              tx_r <= {rd_data_in[14:0], 1'b0};
            end else begin
              serial_out_line_out <= tx_r[15];
              tx_r <= {tx_r[14:0], 1'b0};
            end
          end
        end
      end else begin
        if (i2c_stop) begin
          state_r <= ST_IDLE; // [R16]
          ptr_r <= PTR_RST;
          end_r <= 1'b0;
          sda_oe_out <= 1'b0;
        end else if (i2c_start) begin
          state_r <= ST_IADR; // [R22]
          cnt_r <= 4'h0;
          ack_r <= 1'b0;
          sda_oe_out <= 1'b0;
        end else begin
          case (state_r)
            ST_IADR, ST_IRX: begin
              if (clk_rise && !ack_r) begin
                sh_r <= {sh_r[14:0], sda_s};
                cnt_r <= cnt_r + 4'h1;
              end
              if (clk_fall && ack_r) begin
                ack_r <= 1'b0;
                cnt_r <= 4'h0;
                if (state_r == ST_IADR && rd_dir_r) begin
                  state_r <= ST_ITX;
                  hi_sel_r <= 1'b1;
                  sda_oe_out <= !rd_data_in[15]; // [R24]
                end else begin
                  sda_oe_out <= 1'b0;
                  state_r <= ST_IRX;
                end
              end else if (clk_fall && cnt_r == BYTE_DONE) begin
                if (state_r == ST_IADR) begin
                  if (sh_r[7:1] == own_addr) begin
                    sda_oe_out <= 1'b1; // [R15]
                    ack_r <= 1'b1;
                    rd_dir_r <= sh_r[0];
                    byte_idx_r <= 2'h0;
                  end else begin
                    state_r <= ST_IDLE; // [R15]
                  end
                end else begin
                  sda_oe_out <= 1'b1; // [R21]
                  ack_r <= 1'b1;
                  case (byte_idx_r)
                    2'h0: ptr_r[9:8] <= sh_r[1:0]; // [R17]
                    2'h1: begin
                      ptr_r[7:0] <= sh_r[7:0];
                      end_r <= 1'b0;
                    end
                    2'h2: hi_byte_r <= sh_r[7:0]; // [R18]
                    default: begin
                      push_r <= !end_r; // [R19] [R20] [R25]
                      word_r <= '{addr: ptr_r, data: {hi_byte_r, sh_r[7:0]}};
                      end_r <= end_r | (ptr_r == PTR_MAX);
                      ptr_r <= hsp_adv(ptr_r);
                    end
                  endcase
                  byte_idx_r <= (byte_idx_r == 2'h3) ? 2'h2 : byte_idx_r + 2'h1;
                end
              end
            end
            ST_ITX: begin
              if (clk_rise) begin
                if (cnt_r == BYTE_DONE) begin
                  cnt_r <= 4'h0;
                  if (sda_s) begin
                    state_r <= ST_IDLE;
                  end else begin
                    hi_sel_r <= !hi_sel_r; // [R24]
                    if (!hi_sel_r) begin
                      ptr_r <= hsp_adv(ptr_r);
                    end
                  end
                end else begin
                  cnt_r <= cnt_r + 4'h1;
                end
              end
              if (clk_fall) begin
                if (cnt_r == BYTE_DONE) begin
                  sda_oe_out <= 1'b0;
                end else begin
                  sda_oe_out <= !tx_byte[3'(7 - cnt_r)];
                end
              end
            end
            default: begin
              sda_oe_out <= 1'b0; // [R14]
            end
          endcase
        end
      end
    end
  end
  // Open-drain data line only ever pulls low
  assign sda_out = 1'b0;

  // ===========================================================================
  // Write word buffer toward the register bank
  hsp_fifo #(
    .WIDTH($bits(hsp_wr_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .in_valid_in(push_r),
    .in_ready_out(wr_space_out),
    .in_data_in(word_r),
    .out_valid_out(wr_valid_out),
    .out_ready_in(wr_ready_in),
    .out_data_out(wr_word_out)
  );

  // ===========================================================================
  // Checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  sequence cmd_last_rise;
    !I2C_VARIANT && !cs_n_s && state_r == ST_CMD && clk_rise && cnt_r == WORD_LAST;
  endsequence
  sequence addr_match_fall;
    state_r == ST_IADR && clk_fall && !ack_r && cnt_r == BYTE_DONE && sh_r[7:1] == own_addr
      && !i2c_stop && !i2c_start;
  endsequence

  AST_SDO_HIZ_CMD: assert property ((state_r == ST_CMD || state_r == ST_SKIP)
    |-> !serial_out_line_oe_out) else $error("SERIAL_OUT_LINE driven outside read"); // [R12]
  AST_SDO_ON_FALL: assert property (!I2C_VARIANT && !cs_n_s && $changed(serial_out_line_out)
    |-> $past(clk_fall)) else $error("SERIAL_OUT_LINE changed off falling edge"); // [R01]
  AST_BAD_ENABLE: assert property (cmd_last_rise and
    (cmd_w[CMD_EN_HI:CMD_EN_LO] != CMD_ENABLE) |=> state_r == ST_SKIP)
    else $error("Bad enable pattern accepted"); // [R03]
  AST_PTR_LOAD: assert property (cmd_last_rise and (cmd_w[CMD_EN_HI:CMD_EN_LO] == CMD_ENABLE)
    |=> ptr_r == $past(cmd_w[ADDR_W-1:0]) && !end_r) else $error("Pointer not loaded"); // [R05]
  AST_DIR: assert property (cmd_last_rise and (cmd_w[CMD_EN_HI:CMD_EN_LO] == CMD_ENABLE)
    |=> state_r == ($past(cmd_w[CMD_RW_BIT]) ? ST_SRD : ST_SWR))
    else $error("Direction bit ignored"); // [R04]
  AST_NO_WRAP: assert property ((state_r == ST_SWR || state_r == ST_SRD || state_r == ST_ITX)
    && ptr_r == PTR_MAX && !cs_n_s && !i2c_stop |=> ptr_r == PTR_MAX)
    else $error("Pointer wrapped"); // [R07] [R11] [R24]
  AST_PUSH_LIVE: assert property (push_r |-> $past(!end_r) ##1 !push_r)
    else $error("Discarded word written"); // [R07] [R19]
  AST_STOP_CLEAR: assert property (i2c_stop |=> ptr_r == PTR_RST && state_r == ST_IDLE
    && !sda_oe_out) else $error("Stop did not clear pointer"); // [R16]
  AST_ACK: assert property (addr_match_fall |=> sda_oe_out && ack_r)
    else $error("Address not acknowledged"); // [R15]
  AST_NO_SDA_EDGE_HIGH: assert property (I2C_VARIANT && $changed(sda_oe_out)
    |-> $past(clk_fall || i2c_stop || i2c_start))
    else $error("SDA moved while clock high"); // [R14]
  AST_FIRST_BIT: assert property (!I2C_VARIANT && !cs_n_s && state_r == ST_SRD && clk_fall
    && cnt_r == 4'h0 |=> serial_out_line_oe_out && serial_out_line_out == $past(rd_data_in[15]))
    else $error("First read bit wrong"); // [R10]
endmodule : hsp_port
`default_nettype wire

// *** dv/hsp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module hsp_host_model (
  output logic cs_n_out,
  output logic sclk_out,
  output logic mosi_out,
  input wire logic miso_in,
  input wire logic miso_oe_in,
  output logic sda_low_out,
  input wire logic sda_line_in
);
  localparam int HALF = 100;
  initial begin
    sda_low_out = 1'b0;
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end
  // ==========
  // Frame: command word then nbits data bits, MSB first
  task automatic frame(input logic [15:0] cmd, input int nbits, input logic [255:0] din,
                       input bit idle_hi, output logic [255:0] dout, output logic oe_cmd,
                       output logic oe_any);
    logic [271:0] sh;
    sh = {cmd, din};
    dout = '0;
    oe_cmd = 1'b0;
    oe_any = 1'b0;
    sclk_out = idle_hi;
    #(HALF);
    cs_n_out = 1'b0;
    #(HALF);
    for (int i = 0; i < 16 + nbits; i++) begin
      sclk_out = 1'b0;
      mosi_out = sh[271 - i];
      #(HALF);
      sclk_out = 1'b1;
      #(HALF - 1);
      // Read data sampled at the end of the high phase
      if (i >= 16) begin
        dout = {dout[254:0], miso_in};
      end
      if (i < 16) begin
        oe_cmd = oe_cmd | miso_oe_in;
      end
      oe_any = oe_any | miso_oe_in;
      #1;
    end
    if (!idle_hi) begin
      sclk_out = 1'b0;
    end
    #(HALF);
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #(2 * HALF);
  endtask : frame
  // ==========
  // Two-wire master: clock shared with sclk_out, data line only pulled low
  task automatic i2c_bit(input logic b, output logic r);
    sclk_out = 1'b0;
    #(HALF / 2);
    sda_low_out = !b;
    #(HALF / 2);
    sclk_out = 1'b1;
    #(HALF - 1);
    r = sda_line_in;
    #1;
  endtask : i2c_bit
  // Start when stop is 0, stop when stop is 1
  task automatic i2c_cond(input logic stop);
    sclk_out = 1'b0;
    #(HALF / 2);
    sda_low_out = stop;
    #(HALF / 2);
    sclk_out = 1'b1;
    #(HALF);
    sda_low_out = !stop;
    #(HALF);
  endtask : i2c_cond
  task automatic i2c_wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) i2c_bit(b[i], r);
    i2c_bit(1'b1, ack);
  endtask : i2c_wr
  task automatic i2c_rd(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(1'b1, r);
      b[i] = r;
    end
    i2c_bit(ack, r);
  endtask : i2c_rd
endmodule : hsp_host_model
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hsp_pkg::*;
  logic mclk_in, rst_in, cs_n, sclk, mosi, miso, serial_out_line, sdo_oe;
  logic wr_ready, wr_valid, wr_space, oe_cmd, oe_any;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic [255:0] rd_bits;
  hsp_wr_s wr_word;
  hsp_wr_s got_q[$];
  logic sda_low, sda_line, sda_oe_i, wr_valid_i;
  logic [ADDR_W-1:0] rd_addr_i;
  logic [DATA_W-1:0] rd_data_i;
  hsp_wr_s wr_word_i;
  hsp_wr_s gi_q[$];
  int miscompares;
  int comparisons;

  hsp_port #(.I2C_VARIANT(1'b0)) dut_u (
    .mclk_in(mclk_in), .rst_in(rst_in), .spi_cs_n_in(cs_n), .sclk_in(sclk),
    .serial_in_line_in(mosi), .serial_out_line_out(serial_out_line), .serial_out_line_oe_out(sdo_oe),
    .sda_in(1'b1), .sda_out(), .sda_oe_out(), .addr_strap_low_in(1'b0),
    .addr_strap_high_in(1'b0), .rd_addr_out(rd_addr), .rd_data_in(rd_data),
    .wr_valid_out(wr_valid), .wr_word_out(wr_word), .wr_ready_in(wr_ready),
    .wr_space_out(wr_space)
  );
  hsp_port #(.I2C_VARIANT(1'b1)) dut_i2c_u (
    .mclk_in(mclk_in), .rst_in(rst_in), .spi_cs_n_in(1'b1), .sclk_in(sclk),
    .serial_in_line_in(1'b0), .serial_out_line_out(), .serial_out_line_oe_out(),
    .sda_in(sda_line), .sda_out(), .sda_oe_out(sda_oe_i), .addr_strap_low_in(1'b0),
    .addr_strap_high_in(1'b1), .rd_addr_out(rd_addr_i), .rd_data_in(rd_data_i),
    .wr_valid_out(wr_valid_i), .wr_word_out(wr_word_i), .wr_ready_in(wr_ready),
    .wr_space_out()
  );
  hsp_host_model host_u (
    .cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi), .miso_in(miso), .miso_oe_in(sdo_oe),
    .sda_low_out(sda_low), .sda_line_in(sda_line)
  );
  assign sda_line = !(sda_low || sda_oe_i);
  assign rd_data_i = pat(rd_addr_i);

  // ==========
  // Register bank stand-in and released output line
  function automatic logic [15:0] pat(input logic [9:0] a);
    return {a[5:0], a} ^ 16'hc3a5;
  endfunction : pat
  assign rd_data = pat(rd_addr);
  assign miso = sdo_oe ? serial_out_line : mclk_in;
  initial mclk_in = 1'b0;
  always #12.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    if (rst_in === 1'b0 && wr_valid === 1'b1 && wr_ready === 1'b1) begin
      got_q.push_back(wr_word);
    end
    if (rst_in === 1'b0 && wr_valid_i === 1'b1 && wr_ready === 1'b1) begin
      gi_q.push_back(wr_word_i);
    end
  end

  // ==========
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic settle;
    for (int i = 0; i < 40 && wr_valid !== 1'b0; i++) @(posedge mclk_in);
  endtask : settle
  task automatic wcheck(input logic [9:0] a0, input int n, input logic [255:0] d);
    chk(32'(got_q.size()), 32'(n));
    for (int k = 0; k < n && k < got_q.size(); k++)
      chk({6'h0, got_q[k]}, {6'h0, a0 + 10'(k), d[255 - 16 * k -: 16]});
    got_q.delete();
  endtask : wcheck
  task automatic stop_test;
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // ==========
  // Scenarios
  task automatic sc_write_seq;
    host_u.frame({CMD_ENABLE, 1'b0, 10'h3fd}, 64, {64'ha1b2c3d4e5f60718, 192'h0}, 1'b0,
                 rd_bits, oe_cmd, oe_any);
    settle();
    wcheck(10'h3fd, 3, {48'ha1b2c3d4e5f6, 208'h0});
  endtask : sc_write_seq
  task automatic sc_abort;
    host_u.frame({CMD_ENABLE, 1'b0, 10'h020}, 24, {24'hbeef55, 232'h0}, 1'b1,
                 rd_bits, oe_cmd, oe_any);
    settle();
    wcheck(10'h020, 1, {16'hbeef, 240'h0});
  endtask : sc_abort
  task automatic sc_fill;
    logic [255:0] d;
    d = '0;
    for (int k = 0; k < 9; k++) d[255 - 16 * k -: 16] = 16'h5a00 + 16'(k);
    @(posedge mclk_in);
    #2 wr_ready = 1'b0;
    host_u.frame({CMD_ENABLE, 1'b0, 10'h100}, 144, d, 1'b1, rd_bits, oe_cmd, oe_any);
    chk({31'h0, wr_space}, 32'h0);
    chk({31'h0, wr_valid}, 32'h1);
    chk(32'(got_q.size()), 32'h0);
    @(posedge mclk_in);
    #2 wr_ready = 1'b1;
    settle();
    chk({31'h0, wr_space}, 32'h1);
    wcheck(10'h100, FIFO_DEPTH, d);
  endtask : sc_fill
  task automatic sc_read;
    host_u.frame({CMD_ENABLE, 1'b1, 10'h3fe}, 48, 256'h0, 1'b0, rd_bits, oe_cmd, oe_any);
    chk(rd_bits[47:16], {pat(10'h3fe), pat(10'h3ff)});
    chk({16'h0, rd_bits[15:0]}, {16'h0, pat(10'h3ff)});
    chk({31'h0, oe_cmd}, 32'h0);
    chk({31'h0, sdo_oe}, 32'h0);
    chk(32'(got_q.size()), 32'h0);
  endtask : sc_read
  task automatic sc_bad;
    host_u.frame({5'h1d, 1'b0, 10'h040}, 32, {16'h1234, 240'h0}, 1'b0,
                 rd_bits, oe_cmd, oe_any);
    host_u.frame({5'h0c, 1'b1, 10'h040}, 32, 256'h0, 1'b0, rd_bits, oe_cmd, oe_any);
    chk({31'h0, oe_any}, 32'h0);
    settle();
    chk(32'(got_q.size()), 32'h0);
  endtask : sc_bad
  task automatic sc_i2c;
    logic a;
    logic [7:0] b0, b1, b2, b3;
    logic [47:0] wb;
    wb = 48'hfefe12345678;
    host_u.i2c_cond(1'b0);
    host_u.i2c_wr({7'h2c, 1'b0}, a);
    chk({31'h0, a}, 32'h1);
    host_u.i2c_cond(1'b1);
    host_u.i2c_cond(1'b0);
    host_u.i2c_wr({7'h2e, 1'b0}, a);
    chk({31'h0, a}, 32'h0);
    for (int k = 5; k >= 0; k--) begin
      host_u.i2c_wr(wb[8 * k +: 8], a);
      chk({31'h0, a}, 32'h0);
    end
    host_u.i2c_cond(1'b0);
    host_u.i2c_wr({7'h2e, 1'b1}, a);
    host_u.i2c_rd(1'b0, b0);
    host_u.i2c_rd(1'b0, b1);
    host_u.i2c_rd(1'b0, b2);
    host_u.i2c_rd(1'b1, b3);
    host_u.i2c_cond(1'b1);
    chk({b0, b1, b2, b3}, {pat(10'h300), pat(10'h301)});
    chk(32'(gi_q.size()), 32'h2);
    if (gi_q.size() == 2) begin
      chk({6'h0, gi_q[0]}, {6'h0, 10'h2fe, 16'h1234});
      chk({6'h0, gi_q[1]}, {6'h0, 10'h2ff, 16'h5678});
    end
    host_u.i2c_cond(1'b0);
    host_u.i2c_wr({7'h2e, 1'b1}, a);
    host_u.i2c_rd(1'b0, b0);
    host_u.i2c_rd(1'b1, b1);
    host_u.i2c_cond(1'b1);
    chk({16'h0, b0, b1}, {16'h0, pat(10'h000)});
    chk({31'h0, sda_oe_i}, 32'h0);
  endtask : sc_i2c

  // ==========
  // Main sequence and watchdog
  initial begin
    rst_in = 1'b1;
    wr_ready = 1'b1;
    miscompares = 0;
    comparisons = 0;
    repeat (12) @(posedge mclk_in);
    #2;
    chk({19'h0, rd_addr, wr_valid, wr_space, sdo_oe}, {19'h0, PTR_RST, 3'b010});
    rst_in = 1'b0;
    repeat (4) @(posedge mclk_in);
    sc_write_seq();
    sc_abort();
    sc_fill();
    sc_read();
    sc_bad();
    sc_i2c();
    stop_test();
  end
  // About four times the expected run length
  initial begin
    #500000;
    miscompares++;
    stop_test();
  end
endmodule : tb_top
`default_nettype wire

// *** pkg/hsp_pkg.sv ***
package hsp_pkg;
  // ===========================================================================
  // Pointer and word layout
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] PTR_MAX = 10'h3ff;
  localparam logic [ADDR_W-1:0] PTR_RST = 10'h000;
  // ===========================================================================
  // Command word fields
  localparam int CMD_EN_HI = 15;
  localparam int CMD_EN_LO = 11;
  localparam int CMD_RW_BIT = 10;
  localparam logic [4:0] CMD_ENABLE = 5'h1c;
  // ===========================================================================
  // Two-wire slave address, upper five bits fixed
  localparam logic [4:0] DEV_ADDR_HI = 5'h0b;
  // ===========================================================================
  // Bit counts and write buffer depth
  localparam logic [3:0] WORD_LAST = 4'hf;
  localparam logic [3:0] BYTE_DONE = 4'h8;
  localparam int FIFO_DEPTH = 8;
  // ===========================================================================
  // Register write word handed to the register bank
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } hsp_wr_s;
  // ===========================================================================
  // Link state
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_CMD = 8'h02,
    ST_SWR = 8'h04,
    ST_SRD = 8'h08,
    ST_SKIP = 8'h10,
    ST_IADR = 8'h20,
    ST_IRX = 8'h40,
    ST_ITX = 8'h80
  } hsp_state_e;
endpackage : hsp_pkg
